// [ecq_edge_event_capture_queue.sv]
// Top of the edge event capture queue: register port, queue, holding register, interrupts.
// Assumes a master that keeps strobes one cycle long and never asserts both at once.
`timescale 1ns/1ps
`default_nettype none
module ecq_edge_event_capture_queue
   import ecq_pkg::*;
(
   input  wire logic                      CLK_IN,
   input  wire logic                      SYS_RST_IN,
   input  wire logic                      CLK_EN_IN,
   input  wire logic [ecq_pkg::NUM_IN-1:0] EVT_IN,
   input  wire logic [ecq_pkg::ADDR_W-1:0] ADDR_IN,
   input  wire logic [ecq_pkg::DATA_W-1:0] WDATA_IN,
   input  wire logic                      WR_IN,
   input  wire logic                      RD_IN,
   output var  logic [ecq_pkg::DATA_W-1:0] RDATA_OUT,
   output var  logic                      IRQ_OUT,
   output var  logic                      NEARLY_FULL_OUT,
   output var  logic                      HOLD_VALID_OUT
);
   import ecq_pkg::*;

   // Strobe aimed at one index
   function automatic logic reg_sel(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] t,
                                    input logic              s);
      return s && (a == t);
   endfunction : reg_sel

   // Pointer wraps after the seventh slot
   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      return (p == PTR_LAST) ? '0 : p + 3'd1;
   endfunction : ptr_inc

   ecq_det_if det_bus ();

   // Software-visible state
   logic [NUM_IN-1:0]   ctrl_reg;
   logic [2*NUM_IN-1:0] mode_reg;
   logic [INT_W-1:0]    int_mask_reg;
   logic [INT_W-1:0]    int_stat_reg;
   logic [INT_W-1:0]    int_stat_next;
   logic [TIME_W-1:0]   timer_reg;

   // Queue, holding and latch
   ecq_entry_s          fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0]    rd_ptr_reg;
   logic [PTR_W-1:0]    wr_ptr_reg;
   logic [CNT_W-1:0]    count_reg;
   logic [CNT_W-1:0]    count_next;
   ecq_entry_s          hold_reg;
   logic                hold_valid_reg;
   logic                pend_reg;
   logic [NUM_IN-1:0]   pend_mask_reg;
   logic [NUM_IN-1:0]   acc_mask_reg;

   // Spacing, unload and outputs
   logic [GAP_W-1:0]    gap_reg;
   ecq_unl_e            unl_state;
   logic                nf_reg;
   logic [DATA_W-1:0]   rdata_reg;
   logic                irq_reg;

   // Decoded strobes
   logic wr_ctrl;
   logic wr_mode;
   logic wr_int_stat;
   logic wr_int_mask;
   logic rd_status;
   logic rd_time;

   // Flow control
   logic unload;
   logic hold_free;
   logic adv;
   logic can_push;
   logic rec_ok;
   logic ins_pend;
   logic push_new;
   logic push;
   logic to_latch;
   logic nf_next;
   logic [NUM_IN-1:0] new_mask;
   logic [NUM_IN-1:0] push_mask;
   logic [INT_W-1:0]  int_evt;

   assign wr_ctrl     = reg_sel(ADDR_IN, ADDR_CTRL, WR_IN);
   assign wr_mode     = reg_sel(ADDR_IN, ADDR_MODE, WR_IN);
   assign wr_int_stat = reg_sel(ADDR_IN, ADDR_INT_STAT, WR_IN);
   assign wr_int_mask = reg_sel(ADDR_IN, ADDR_INT_MASK, WR_IN);
   assign rd_status   = reg_sel(ADDR_IN, ADDR_STATUS, RD_IN);
   assign rd_time     = reg_sel(ADDR_IN, ADDR_TIME, RD_IN);

   assign det_bus.mode      = mode_reg;
   assign det_bus.enable    = ctrl_reg;
   assign det_bus.presc_clr = wr_mode;

   // Edge detection and prescalers
   ecq_edge_det u_det (
      .clk_in (CLK_IN),
      .rst_in (SYS_RST_IN),
      .ce_in  (CLK_EN_IN),
      .evt_in (EVT_IN),
      .det    (det_bus.det)
   );

   // Software registers
   // Writes to read-only indices are dropped
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_reg     <= CTRL_RST;
         mode_reg     <= MODE_RST;
         int_mask_reg <= INT_RST;
      end else if (CLK_EN_IN) begin
         if (wr_ctrl) begin
            ctrl_reg <= WDATA_IN[NUM_IN-1:0];
         end
         if (wr_mode) begin
            mode_reg <= WDATA_IN[2*NUM_IN-1:0];
         end
         if (wr_int_mask) begin
            int_mask_reg <= WDATA_IN[INT_W-1:0];
         end
      end
   end

   // Free-running time base, one count per state time
   // Wraps silently; stamps are modulo its width
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         timer_reg <= TIMER_RST;
      end else if (CLK_EN_IN) begin
         timer_reg <= timer_reg + 16'h0001;
      end
   end

   // A time read with no status read first unloads nothing
   // unload needs status read, then time read
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         unl_state <= UNL_IDLE;
      end else if (CLK_EN_IN) begin
         case (unl_state)
            UNL_IDLE: begin
               if (rd_status) begin
                  unl_state <= UNL_ARMED;
               end
            end
            UNL_ARMED: begin
               if (rd_time) begin
                  unl_state <= UNL_IDLE;
               end
            end
            // Illegal codes fall back to idle
            default: unl_state <= UNL_IDLE;
         endcase
      end
   end

   // Queue flow control
   always_comb begin
      unload    = rd_time && (unl_state == UNL_ARMED) && hold_valid_reg;
      hold_free = !hold_valid_reg || unload;
      adv       = hold_free && (count_reg != '0);
      // seven queue slots, eighth in holding
      can_push  = (count_reg != FIFO_FULL_CNT) || adv;
      // Edges seen in the gap merge into one record
      new_mask  = acc_mask_reg | det_bus.hit;
      rec_ok    = (gap_reg == '0) && (new_mask != '0);
      ins_pend  = pend_reg && can_push;
      push_new  = rec_ok && can_push && !pend_reg;
      push      = ins_pend || push_new;
      push_mask = ins_pend ? pend_mask_reg : new_mask;
      // While latched, new events join the latch
      // no room: latch instead of queue
      to_latch  = rec_ok && (!can_push || pend_reg);

      // Push with advance keeps the count
      // inserted latch counts as a real entry
      case ({push, adv})
         2'b10:   count_next = count_reg + 3'd1;
         2'b01:   count_next = count_reg - 3'd1;
         default: count_next = count_reg;
      endcase
      nf_next = (count_next >= NF_LEVEL);
   end

   // Spacing counter and accumulation of edges seen during the gap
   // nine-cycle spacing
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         gap_reg      <= '0;
         acc_mask_reg <= '0;
      end else if (CLK_EN_IN) begin
         if (rec_ok) begin
            gap_reg      <= GAP_RELOAD;
            acc_mask_reg <= '0;
         end else if (gap_reg != '0) begin
            gap_reg      <= gap_reg - 4'd1;
            acc_mask_reg <= acc_mask_reg | det_bus.hit;
         end
      end
   end

   // Pending-event latch
   // latch when full
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         pend_reg      <= 1'b0;
         pend_mask_reg <= '0;
      end else if (CLK_EN_IN) begin
         // Insert and re-latch may share a cycle
         if (ins_pend) begin
            pend_reg      <= to_latch;
            pend_mask_reg <= to_latch ? new_mask : '0;
         end else if (to_latch) begin
            pend_reg      <= 1'b1;
            pend_mask_reg <= pend_mask_reg | new_mask;
         end
      end
   end

   // Queue storage, pointers and fill count
   // Storage has no reset; pointers and count decide validity
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         count_reg  <= '0;
         nf_reg     <= 1'b0;
      end else if (CLK_EN_IN) begin
         if (push) begin
            fifo_mem[wr_ptr_reg] <= '{mask: push_mask, stamp: timer_reg};
            wr_ptr_reg           <= ptr_inc(wr_ptr_reg);
         end
         if (adv) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         count_reg <= count_next;
         nf_reg    <= nf_next;
      end
   end

   // Holding register
   // eighth storage slot
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         hold_reg       <= '0;
         hold_valid_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         if (adv) begin
            hold_reg       <= fifo_mem[rd_ptr_reg];
            hold_valid_reg <= 1'b1;
         end else if (unload) begin
            // Emptied only when nothing waits
            hold_valid_reg <= 1'b0;
         end
      end
   end

   // Fourth-entry source fires only on the way up
   // three interrupt sources
   always_comb begin
      int_evt                 = '0;
      int_evt[INT_NF_BIT]     = nf_next && !nf_reg;
      int_evt[INT_FOURTH_BIT] = (count_next == FOURTH_LEVEL) && (count_reg < FOURTH_LEVEL);
      // Any move into holding
      int_evt[INT_AVAIL_BIT]  = adv;
      // New events win over a write-one clear
      int_stat_next = int_stat_reg;
      if (wr_int_stat) begin
         int_stat_next = int_stat_reg & ~WDATA_IN[INT_W-1:0];
      end
      int_stat_next = int_stat_next | int_evt;
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         int_stat_reg <= INT_RST;
         irq_reg      <= 1'b0;
      end else if (CLK_EN_IN) begin
         int_stat_reg <= int_stat_next;
         irq_reg      <= |(int_stat_reg & int_mask_reg);
      end
   end

   // Read data, valid only in the cycle after the strobe
   // Unmapped indices read back as zero
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         rdata_reg <= '0;
      end else if (CLK_EN_IN) begin
         rdata_reg <= '0;
         if (RD_IN) begin
            if (ADDR_IN == ADDR_CTRL) begin
               rdata_reg[NUM_IN-1:0] <= ctrl_reg;
            end else if (ADDR_IN == ADDR_MODE) begin
               rdata_reg[2*NUM_IN-1:0] <= mode_reg;
            end else if (ADDR_IN == ADDR_STATUS) begin
               rdata_reg[NUM_IN-1:0]                   <= hold_reg.mask;
               rdata_reg[STAT_LVL_LSB +: NUM_IN]       <= det_bus.level;
               rdata_reg[STAT_HV_BIT]                  <= hold_valid_reg;
            end else if (ADDR_IN == ADDR_TIME) begin
               rdata_reg[TIME_W-1:0] <= hold_reg.stamp;
            end else if (ADDR_IN == ADDR_IOS) begin
               rdata_reg[IOS_NF_BIT]             <= nf_reg;
               rdata_reg[IOS_HV_BIT]             <= hold_valid_reg;
               rdata_reg[IOS_PEND_BIT]           <= pend_reg;
               rdata_reg[IOS_CNT_LSB +: CNT_W]   <= count_reg;
            end else if (ADDR_IN == ADDR_INT_STAT) begin
               rdata_reg[INT_W-1:0] <= int_stat_reg;
            end else if (ADDR_IN == ADDR_INT_MASK) begin
               rdata_reg[INT_W-1:0] <= int_mask_reg;
            end else if (ADDR_IN == ADDR_TIMER) begin
               rdata_reg[TIME_W-1:0] <= timer_reg;
            end
         end
      end
   end

   // Every output comes straight from a flop
   assign RDATA_OUT       = rdata_reg;
   assign IRQ_OUT         = irq_reg;
   assign NEARLY_FULL_OUT = nf_reg;
   assign HOLD_VALID_OUT  = hold_valid_reg;
endmodule : ecq_edge_event_capture_queue
`default_nettype wire

// [ecq_pkg.sv]
// Constants, types and register map of the edge event capture queue.
// Assumes one clock where one cycle is one state time; all users import the package.
// How it works
// - Queue keeps seven events plus one in holding register, each with status and time.
// - Status read then time read unloads holding; oldest queued event then advances.
// - Event arriving with queue and holding full sets the pending-event latch instead.
// - Pending latched event enters queue as soon as a slot frees after unload.
// - Latched event is time tagged on entry to queue, not at transition.
// - Nearly-full flag is set while queue holds six or more events.
// - Holding-valid flag is set while the holding register holds an event.
// - Flags count an inserted latched event exactly like a real captured event.
// - A new event is recorded at most once every nine state times.
// - Every capture mode register write resets all the per-input divide-by-eight prescalers.
// - So inputs in divide-by-eight mode lose up to seven counted transitions.
// - Divide-by-eight mode loads every eighth rising edge; other modes each rising, falling or any edge.
// - Clearing an input enable in io_control_zero stops it loading events.
// - Three interrupt sources: nearly full, fourth entry filled, data available.
package ecq_pkg;
   localparam int NUM_IN     = 4;
   localparam int TIME_W     = 16;
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 4;
   localparam int PTR_W      = 3;
   localparam int CNT_W      = 3;
   localparam int GAP_W      = 4;
   localparam int INT_W      = 3;
   localparam int FIFO_DEPTH = 7;

   localparam logic [PTR_W-1:0] PTR_LAST      = 3'd6;
   localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 3'd7;
   localparam logic [CNT_W-1:0] NF_LEVEL      = 3'd6;
   localparam logic [CNT_W-1:0] FOURTH_LEVEL  = 3'd4;
   localparam logic [2:0]       PRESC_LAST    = 3'd7;

   // Timing: one state time per clock at 40 MHz
   localparam int CLK_PERIOD_NS  = 25;
   localparam int STATE_TIME_NS  = 25;
   localparam int MIN_GAP_ST     = 9;
   localparam int MIN_GAP_CYCLES = (MIN_GAP_ST * STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [GAP_W-1:0] GAP_RELOAD = GAP_W'(MIN_GAP_CYCLES - 1);

   // Register indices on the plain register port
   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_MODE     = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_TIME     = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_IOS      = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_TIMER    = 4'h7;

   // Field positions
   localparam int IOS_NF_BIT     = 0;
   localparam int IOS_HV_BIT     = 1;
   localparam int IOS_PEND_BIT   = 2;
   localparam int IOS_CNT_LSB    = 4;
   localparam int STAT_LVL_LSB   = 4;
   localparam int STAT_HV_BIT    = 8;
   localparam int INT_NF_BIT     = 0;
   localparam int INT_FOURTH_BIT = 1;
   localparam int INT_AVAIL_BIT  = 2;

   // Reset values
   localparam logic [NUM_IN-1:0]   CTRL_RST  = 4'h0;
   localparam logic [2*NUM_IN-1:0] MODE_RST  = 8'h00;
   localparam logic [INT_W-1:0]    INT_RST   = 3'h0;
   localparam logic [TIME_W-1:0]   TIMER_RST = 16'h0000;

   typedef enum logic [1:0] {
      MODE_DIV8 = 2'b00,
      MODE_POS  = 2'b01,
      MODE_NEG  = 2'b10,
      MODE_ANY  = 2'b11
   } ecq_mode_e;

   typedef enum logic [1:0] {
      UNL_IDLE  = 2'b01,
      UNL_ARMED = 2'b10
   } ecq_unl_e;

   typedef struct packed {
      logic [NUM_IN-1:0] mask;
      logic [TIME_W-1:0] stamp;
   } ecq_entry_s;
endpackage : ecq_pkg

// [ecq_det_if.sv]
// Carrier between the capture core and the edge detector.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface ecq_det_if;
   import ecq_pkg::*;
   logic [2*NUM_IN-1:0] mode;
   logic [NUM_IN-1:0]   enable;
   logic                presc_clr;
   logic [NUM_IN-1:0]   hit;
   logic [NUM_IN-1:0]   level;
   modport det  (input mode, enable, presc_clr, output hit, level);
   modport core (output mode, enable, presc_clr, input hit, level);
endinterface : ecq_det_if
`default_nettype wire

// [ecq_edge_det.sv]
// Per-input transition detector with divide-by-eight prescalers.
// Assumes event inputs are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module ecq_edge_det
   import ecq_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              ce_in,
   input  wire logic [NUM_IN-1:0] evt_in,
   ecq_det_if.det                 det
);
   import ecq_pkg::*;

   logic [NUM_IN-1:0] prev_reg;
   logic [NUM_IN-1:0] hit_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prev_reg <= '0;
      end else if (ce_in) begin
         prev_reg <= evt_in;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         logic       pos;
         logic       neg;
         logic       sel;
         logic [2:0] presc_reg;
         ecq_mode_e  md;
         assign pos = evt_in[gi] & ~prev_reg[gi];
         assign neg = ~evt_in[gi] & prev_reg[gi];
         assign md  = ecq_mode_e'(det.mode[2*gi +: 2]);

         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               presc_reg <= '0;
            end else if (ce_in) begin
               if (det.presc_clr) begin
                  presc_reg <= '0;
               end else if (pos) begin
                  presc_reg <= presc_reg + 3'd1;
               end
            end
         end

         // eighth rising edge, or each rising, falling or any edge
         always_comb begin
            case (md)
               MODE_DIV8: sel = pos && (presc_reg == PRESC_LAST) && !det.presc_clr;
               MODE_POS:  sel = pos;
               MODE_NEG:  sel = neg;
               default:   sel = pos | neg;
            endcase
         end

         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               hit_reg[gi] <= 1'b0;
            end else if (ce_in) begin
               hit_reg[gi] <= sel & det.enable[gi];
            end
         end
      end
   endgenerate

   assign det.hit   = hit_reg;
   assign det.level = prev_reg;
endmodule : ecq_edge_det
`default_nettype wire

// [ecq_evt_src.sv]
// Behavioural source of the event lines: toggles the chosen lines on request.
// Assumes requests are one-cycle pulses on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module ecq_evt_src
   import ecq_pkg::*;
(
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       fire_in,
   input  wire logic [ecq_pkg::NUM_IN-1:0] mask_in,
   output var  logic [ecq_pkg::NUM_IN-1:0] evt_out
);
   import ecq_pkg::*;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         evt_out <= '0;
      end else if (fire_in) begin
         evt_out <= evt_out ^ mask_in;
      end
   end
endmodule : ecq_evt_src
`default_nettype wire

// [ecq_monitor.sv]
// Concurrent checks on the ports of the capture queue top.
// Assumes it is bound into the top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ecq_monitor
   import ecq_pkg::*;
(
   input wire logic                       CLK_IN,
   input wire logic                       SYS_RST_IN,
   input wire logic                       CLK_EN_IN,
   input wire logic [ecq_pkg::ADDR_W-1:0] ADDR_IN,
   input wire logic [ecq_pkg::DATA_W-1:0] WDATA_IN,
   input wire logic                       WR_IN,
   input wire logic                       RD_IN,
   input wire logic [ecq_pkg::DATA_W-1:0] RDATA_OUT,
   input wire logic                       IRQ_OUT,
   input wire logic                       NEARLY_FULL_OUT,
   input wire logic                       HOLD_VALID_OUT
);
   import ecq_pkg::*;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   logic [NUM_IN-1:0]   ctrl_q;
   logic [2*NUM_IN-1:0] mode_q;
   logic [INT_W-1:0]    mask_q;

   // Shadow copies of the writable registers
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_q <= '0;
         mode_q <= '0;
         mask_q <= '0;
      end else if (WR_IN && CLK_EN_IN) begin
         if (ADDR_IN == ADDR_CTRL) ctrl_q <= WDATA_IN[NUM_IN-1:0];
         if (ADDR_IN == ADDR_MODE) mode_q <= WDATA_IN[2*NUM_IN-1:0];
         if (ADDR_IN == ADDR_INT_MASK) mask_q <= WDATA_IN[INT_W-1:0];
      end
   end

   rst_out_a: assert property (disable iff (1'b0)
      SYS_RST_IN |=> {RDATA_OUT, IRQ_OUT, NEARLY_FULL_OUT, HOLD_VALID_OUT} == '0)
      else $error("outputs not cleared by reset");
   rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == '0)
      else $error("read data without a read");
   unmapped_a: assert property (RD_IN && ADDR_IN[3] |=> RDATA_OUT == '0)
      else $error("unmapped read not zero");
   ctrl_rb_a: assert property (
      RD_IN && ADDR_IN == ADDR_CTRL |=> RDATA_OUT == DATA_W'($past(ctrl_q)))
      else $error("enable register readback wrong");
   mode_rb_a: assert property (
      RD_IN && ADDR_IN == ADDR_MODE |=> RDATA_OUT == DATA_W'($past(mode_q)))
      else $error("mode register readback wrong");
   hold_fall_a: assert property (
      $fell(HOLD_VALID_OUT) |-> $past(RD_IN && ADDR_IN == ADDR_TIME) || $past(RD_IN && ADDR_IN == ADDR_TIME, 2))
      else $error("holding emptied without unload");
   nf_hv_a: assert property (NEARLY_FULL_OUT |-> HOLD_VALID_OUT)
      else $error("nearly full while holding empty");
   irq_masked_a: assert property (
      mask_q == '0 && $past(mask_q) == '0 && $past(mask_q, 2) == '0 |-> !IRQ_OUT)
      else $error("interrupt while fully masked");

   nf_cover_c: cover property ($rose(NEARLY_FULL_OUT));
   irq_cover_c: cover property ($rose(IRQ_OUT));
   unload_cover_c: cover property ($fell(HOLD_VALID_OUT));
endmodule : ecq_monitor
`default_nettype wire

// [tb.sv]
// Self-checking bench of the edge event capture queue with a toggling event source.
// Assumes the package constants; one state time per 25 ns clock; seeded stimulus.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ecq_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              ce = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              fire = 1'b0;
   logic [NUM_IN-1:0] fmask = '0;
   logic [NUM_IN-1:0] evt;
   logic [DATA_W-1:0] rdata;
   logic              irq;
   logic              nf;
   logic              hv;
   int                fail_count = 0;
   int                check_count = 0;
   int                cyc = 0;
   int                fire_cyc;
   int                cp;
   logic [DATA_W-1:0] s;
   logic [DATA_W-1:0] t;
   logic [DATA_W-1:0] t0;
   logic [NUM_IN-1:0] m;

   always #12.5 clk = ~clk;

   ecq_edge_event_capture_queue i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(ce), .EVT_IN(evt),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq),
      .NEARLY_FULL_OUT(nf), .HOLD_VALID_OUT(hv));
   ecq_evt_src i_src (.clk_in(clk), .rst_in(rst), .fire_in(fire), .mask_in(fmask), .evt_out(evt));

   task automatic wrap_up;
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_out(input logic [2:0] exp);
      #1;
      chk(DATA_W'({irq, nf, hv}), DATA_W'(exp));
   endtask : chk_out

   function automatic logic [DATA_W-1:0] ios_exp(input int cnt, input logic hold, input logic pend);
      ios_exp = '0;
      ios_exp[IOS_CNT_LSB +: 3] = cnt[2:0];
      ios_exp[IOS_NF_BIT] = (cnt >= 6);
      ios_exp[IOS_HV_BIT] = hold;
      ios_exp[IOS_PEND_BIT] = pend;
   endfunction : ios_exp

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic unload;
      rd_reg(ADDR_STATUS, s);
      rd_reg(ADDR_TIME, t);
      repeat (3) @(posedge clk);
   endtask : unload

   task automatic ev(input logic [NUM_IN-1:0] msk);
      @(posedge clk);
      fire <= 1'b1;
      fmask <= msk;
      #1;
      fire_cyc = cyc;
      @(posedge clk);
      fire <= 1'b0;
   endtask : ev

   task automatic wait_hv(input logic e);
      int n;
      n = 0;
      #1;
      while (hv !== e && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(DATA_W'(hv), DATA_W'(e));
   endtask : wait_hv

   // Each iteration gives exactly one rising edge on line zero
   task automatic pulses(input int n);
      repeat (n) begin
         ev(4'h1);
         repeat (4) @(posedge clk);
         ev(4'h1);
         repeat (6) @(posedge clk);
      end
   endtask : pulses

   initial begin
      void'($urandom(21));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wr_reg(4'h9, 16'hffff);
      for (int a = 0; a < 16; a++) begin
         if (a != 7) begin
            rd_reg(ADDR_W'(a), s);
            chk(s, 16'h0000);
         end
      end
      // Twenty frozen cycles leave the timer three counts on
      rd_reg(ADDR_TIMER, t0);
      @(posedge clk);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      rd_reg(ADDR_TIMER, t);
      chk(t - t0, 16'd3);
      wr_reg(ADDR_MODE, 16'h00ff);
      wr_reg(ADDR_CTRL, 16'h000f);
      for (int k = 0; k < 6; k++) begin
         m = NUM_IN'($urandom_range(15, 1));
         ev(m);
         wait_hv(1'b1);
         unload();
         chk(DATA_W'(s[NUM_IN-1:0]), DATA_W'(m));
         if (k > 0) chk(t - t0, DATA_W'(fire_cyc - cp));
         t0 = t;
         cp = fire_cyc;
         wait_hv(1'b0);
         repeat ($urandom_range(8, 0)) @(posedge clk);
      end
      ev(4'h1);
      ev(4'h2);
      repeat (25) @(posedge clk);
      unload();
      t0 = t;
      unload();
      chk(DATA_W'(s[NUM_IN-1:0]), 16'h0002);
      chk(DATA_W'((t - t0) >= 16'd9), 16'h0001);
      wr_reg(ADDR_INT_STAT, 16'h0007);
      for (int k = 0; k < 9; k++) begin
         ev(4'h1);
         repeat (12) @(posedge clk);
      end
      rd_reg(ADDR_IOS, s);
      chk(s, ios_exp(7, 1'b1, 1'b1));
      rd_reg(ADDR_INT_STAT, s);
      chk(s, 16'h0007);
      chk_out(3'b011);
      wr_reg(ADDR_INT_MASK, 16'h0001);
      repeat (3) @(posedge clk);
      chk_out(3'b111);
      wr_reg(ADDR_INT_STAT, 16'h0001);
      repeat (3) @(posedge clk);
      chk_out(3'b011);
      for (int k = 1; k <= 9; k++) begin
         chk_out({1'b0, k <= 3, 1'b1});
         unload();
         if (k > 1 && k < 9) chk(t - t0, 16'd14);
         if (k == 9) chk(DATA_W'((t - t0) > 16'd14), 16'h0001);
         t0 = t;
      end
      chk_out(3'b000);
      rd_reg(ADDR_INT_STAT, s);
      chk(s, 16'h0006);
      wr_reg(ADDR_INT_MASK, 16'h0004);
      repeat (3) @(posedge clk);
      chk_out(3'b100);
      wr_reg(ADDR_INT_STAT, 16'h0007);
      wr_reg(ADDR_INT_MASK, 16'h0000);
      repeat (3) @(posedge clk);
      chk_out(3'b000);
      wr_reg(ADDR_MODE, 16'h0000);
      wr_reg(ADDR_CTRL, 16'h0001);
      pulses(7);
      chk_out(3'b000);
      pulses(1);
      wait_hv(1'b1);
      unload();
      pulses(5);
      wr_reg(ADDR_MODE, 16'h0000);
      pulses(7);
      chk_out(3'b000);
      pulses(1);
      wait_hv(1'b1);
      unload();
      wr_reg(ADDR_CTRL, 16'h0000);
      pulses(8);
      chk_out(3'b000);
      wr_reg(ADDR_CTRL, 16'h0001);
      for (int md = 1; md < 4; md++) begin
         wr_reg(ADDR_MODE, DATA_W'(md));
         ev(4'h1);
         repeat (12) @(posedge clk);
         ev(4'h1);
         repeat (12) @(posedge clk);
         rd_reg(ADDR_IOS, s);
         chk(s, ios_exp(md == 3, 1'b1, 1'b0));
         repeat (1 + (md == 3)) unload();
         wait_hv(1'b0);
      end
      wrap_up();
   end
endmodule : tb

bind ecq_edge_event_capture_queue ecq_monitor i_mon (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .CLK_EN_IN(CLK_EN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .NEARLY_FULL_OUT(NEARLY_FULL_OUT), .HOLD_VALID_OUT(HOLD_VALID_OUT));
`default_nettype wire
